/* File: src/exc_pkg.sv */
package exc_pkg;

  // ------------------------------------------------------------------
  // Register map on the plain software port.
  // ------------------------------------------------------------------
  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_CAUSE     = 8'h04;
  localparam logic [7:0]  OFF_EPC       = 8'h08;
  localparam logic [7:0]  OFF_ERROR_EPC = 8'h0C;
  localparam logic [7:0]  OFF_WATCH     = 8'h10;
  localparam logic [7:0]  OFF_INTREG    = 8'h14;

  // ------------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------------
  localparam int ST_IE   = 0;
  localparam int ST_EXL  = 1;
  localparam int ST_ERL  = 2;
  localparam int ST_SR   = 20;
  localparam int ST_BIT21 = 21;
  localparam int ST_BEV  = 22;
  localparam int CA_BD   = 31;
  localparam int CA_CE_LO = 28;
  localparam int CA_IV   = 23;
  localparam int CA_IP_LO = 8;
  localparam int CA_CODE_LO = 2;
  localparam int WA_IW   = 0;
  localparam int WA_DWR  = 1;
  localparam int WA_DWW  = 2;
  localparam int INT_NMI = 6;
  localparam logic [31:0] CAUSE_WR_MASK = 32'h0080_0300;
  localparam logic [31:0] STATUS_RST    = 32'h0040_0004;

  // ------------------------------------------------------------------
  // Vector bases and offsets.
  // ------------------------------------------------------------------
  localparam logic [31:0] VEC_RESET      = 32'hBFC0_0000;
  localparam logic [31:0] BASE_BEV0      = 32'h8000_0000;
  localparam logic [31:0] BASE_BEV1      = 32'hBFC0_0200;
  localparam logic [31:0] CERR_BASE_BEV0 = 32'hA000_0000;
  localparam logic [31:0] CERR_BASE_BEV1 = 32'hBFC0_0200;
  localparam logic [31:0] OFF_VCACHE     = 32'h0000_0100;
  localparam logic [31:0] OFF_VGEN       = 32'h0000_0180;
  localparam logic [31:0] OFF_VINT       = 32'h0000_0200;

  // ------------------------------------------------------------------
  // Priority levels and exception codes.
  // ------------------------------------------------------------------
  localparam logic [3:0] P_COLD = 4'h1;
  localparam logic [3:0] P_WARM = 4'h2;
  localparam logic [3:0] P_NMI  = 4'h3;
  localparam logic [3:0] P_IBND = 4'h4;
  localparam logic [3:0] P_IADR = 4'h5;
  localparam logic [3:0] P_IWCH = 4'h6;
  localparam logic [3:0] P_ICER = 4'h7;
  localparam logic [3:0] P_IBUS = 4'h8;
  localparam logic [3:0] P_GRP9 = 4'h9;
  localparam logic [3:0] P_DBND = 4'hA;
  localparam logic [3:0] P_DADR = 4'hB;
  localparam logic [3:0] P_DCER = 4'hC;
  localparam logic [3:0] P_DWCH = 4'hD;
  localparam logic [3:0] P_DBUS = 4'hE;
  localparam logic [3:0] P_INTR = 4'hF;
  localparam logic [4:0] EC_INT   = 5'h00;
  localparam logic [4:0] EC_IBND  = 5'h02;
  localparam logic [4:0] EC_DBND  = 5'h03;
  localparam logic [4:0] EC_ADEL  = 5'h04;
  localparam logic [4:0] EC_ADES  = 5'h05;
  localparam logic [4:0] EC_IBE   = 5'h06;
  localparam logic [4:0] EC_DBE   = 5'h07;
  localparam logic [4:0] EC_WATCH = 5'h17;

  typedef enum logic [1:0] {
    VK_GENERAL = 2'b00,
    VK_INTR    = 2'b01,
    VK_CACHE   = 2'b11,
    VK_RESET   = 2'b10
  } vec_kind_t;

endpackage

/* File: src/exc_sel_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface exc_sel_if;
  import exc_pkg::*;
  logic [15:1] raise;
  logic        win_valid;
  logic [3:0]  win_prio;
  vec_kind_t   kind;
  logic        boot_vector_select;
  logic        iv;
  logic [31:0] vector;
  modport prio (input raise, output win_valid, win_prio);
  modport vec  (input kind, boot_vector_select, iv, output vector);
  modport core (output raise, kind, boot_vector_select, iv,
                input win_valid, win_prio, vector);
endinterface // exc_sel_if
`default_nettype wire

/* File: src/exc_prio_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module exc_prio_pick (
  exc_sel_if.prio sel
);
  import exc_pkg::*;

  // Lowest set index is the highest priority.
  logic [3:0] pick [16];
  assign pick[0] = 4'h0;
  genvar g;
  generate
    for (g = 15; g >= 1; g--) begin : g_lvl
      assign pick[16-g] = sel.raise[g] ? 4'(g) : pick[15-g];
    end
  endgenerate

  assign sel.win_valid = |sel.raise;
  assign sel.win_prio  = pick[15];
endmodule // exc_prio_pick
`default_nettype wire

/* File: src/exc_vector_form.sv */
`timescale 1ns/1ps
`default_nettype none
module exc_vector_form (
  exc_sel_if.vec sel
);
  import exc_pkg::*;

  wire [31:0] gen_base  = sel.boot_vector_select ? BASE_BEV1 : BASE_BEV0;
  wire [31:0] cerr_base = sel.boot_vector_select ? CERR_BASE_BEV1 : CERR_BASE_BEV0;
  wire [31:0] int_off   = sel.iv ? OFF_VINT : OFF_VGEN;

  always_comb begin
    unique case (sel.kind)
      VK_RESET:   sel.vector = VEC_RESET;
      VK_CACHE:   sel.vector = cerr_base + OFF_VCACHE;
      VK_INTR:    sel.vector = gen_base + int_off;
      VK_GENERAL: sel.vector = gen_base + OFF_VGEN;
    endcase
  end
endmodule // exc_vector_form
`default_nettype wire

/* File: src/exception_vector_priority_unit.sv */
// Overview of operation
// - Resets and NMI vector to fixed address.
// - Other bases follow boot vector select.
// - Offsets: cache 100, others 180, interrupt 200 when IV set.
// - Cache error base uncached when select clear.
// - Report only highest priority, levels one-eight.
// - Levels nine to fifteen, interrupt lowest.
// - General exception rewrites cause, keeps 15:8.
// - Return PC captured only if level clear.
// - Interrupt offset by vector select, base by 22.
// - Cold reset taken on deassertion, unmaskable.
// - Cold reset: flag zero, error level, select one.
// - Cold reset clears vector select, watch enables.
// - Reset vector lies unmapped and uncached.
// - Warm reset starts on deassertion, unmaskable.
// - Warm reset saves PC, sets three bits.
// - Warm reset resets cache and bus machines.
// - NMI on pin fall or bit six write.
// - NMI ignores level and enable bits.
// - NMI at boundary; resets taken immediately.
// - NMI saves PC, sets three status bits.
// - Exception codes use the fixed encodings.
// - Cache error sets level, saves PC, vectors.
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module exception_vector_priority_unit (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // System pins.
  input  wire logic        cold_reset_n,
  input  wire logic        warm_reset_n,
  input  wire logic        nmi_n,
  // Pipeline exception request.
  input  wire logic [15:4] exc_raise,
  input  wire logic [4:0]  grp9_code,
  input  wire logic        data_is_store,
  input  wire logic        exc_bd,
  input  wire logic [1:0]  exc_ce,
  input  wire logic [31:0] pipe_pc,
  input  wire logic        instr_boundary,
  // Software register port.
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Fetch redirection.
  output logic             redirect_valid,
  output logic      [31:0] redirect_pc,
  output logic             flush_younger,
  output logic      [4:0]  reported_code,
  output logic      [3:0]  reported_prio,
  output logic             fetch_hold,
  output logic             cache_bus_reset,
  output logic      [31:0] status_out
);
  import exc_pkg::*;

  // ------------------------------------------------------------------
  // Reset release and pin synchronisers.
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_int_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  logic [2:0] pin_raw;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_old_q;
  assign pin_raw = {nmi_n, warm_reset_n, cold_reset_n};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
          pin_s1_q[gi]  <= 1'b1;
          pin_s2_q[gi]  <= 1'b1;
          pin_old_q[gi] <= 1'b1;
        end else begin
          pin_s1_q[gi]  <= pin_raw[gi];
          pin_s2_q[gi]  <= pin_s1_q[gi];
          pin_old_q[gi] <= pin_s2_q[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Pin events.
  // ------------------------------------------------------------------
  wire cold_rise = pin_s2_q[0] & ~pin_old_q[0];
  wire warm_rise = pin_s2_q[1] & ~pin_old_q[1];
  wire nmi_fall  = ~pin_s2_q[2] & pin_old_q[2];
  wire rst_held  = ~pin_s2_q[0] | ~pin_s2_q[1];

  // ------------------------------------------------------------------
  // Architectural registers.
  // ------------------------------------------------------------------
  logic [31:0] status_q, status_d;
  logic [31:0] cause_q, cause_d;
  logic [31:0] epc_q, epc_d;
  logic [31:0] eepc_q, eepc_d;
  logic [2:0]  watch_q, watch_d;
  logic        nmi_pend_q;
  logic        nmi_pend_d;

  // ------------------------------------------------------------------
  // Register port decode.
  // ------------------------------------------------------------------
  wire hit_status = reg_addr == OFF_STATUS;
  wire hit_cause  = reg_addr == OFF_CAUSE;
  wire hit_epc    = reg_addr == OFF_EPC;
  wire hit_eepc   = reg_addr == OFF_ERROR_EPC;
  wire hit_watch  = reg_addr == OFF_WATCH;
  wire hit_intreg = reg_addr == OFF_INTREG;
  wire wr_status  = reg_wr & hit_status;
  wire wr_cause   = reg_wr & hit_cause;
  wire wr_epc     = reg_wr & hit_epc;
  wire wr_eepc    = reg_wr & hit_eepc;
  wire wr_watch   = reg_wr & hit_watch;
  wire wr_nmi     = reg_wr & hit_intreg & reg_wdata[INT_NMI];

  logic [31:0] rd_mux;
  assign rd_mux = hit_status ? status_q :
                  hit_cause  ? cause_q :
                  hit_epc    ? epc_q :
                  hit_eepc   ? eepc_q :
                  hit_watch  ? {29'h0, watch_q} :
                  32'h0000_0000;

  // ------------------------------------------------------------------
  // Exception selection.
  // ------------------------------------------------------------------
  exc_sel_if sel ();

  // NMI is unmaskable but waits for an instruction boundary; resets
  // do not wait.
  wire nmi_take_req = nmi_pend_q & instr_boundary;

  assign sel.raise = {exc_raise, nmi_take_req, warm_rise, cold_rise};

  exc_prio_pick u_pick (
    .sel (sel)
  );

  exc_vector_form u_vec (
    .sel (sel)
  );

  wire [3:0] win   = sel.win_prio;
  wire       taken = sel.win_valid;
  wire       is_rst_kind = (win == P_COLD) | (win == P_WARM) |
                           (win == P_NMI);
  wire       is_cerr = (win == P_ICER) | (win == P_DCER);
  wire       is_intr = win == P_INTR;
  wire       is_gen  = taken & ~is_rst_kind & ~is_cerr;

  assign sel.kind = is_rst_kind ? VK_RESET :
                    is_cerr     ? VK_CACHE :
                    is_intr     ? VK_INTR :
                    VK_GENERAL;
  assign sel.boot_vector_select = status_q[ST_BEV];
  assign sel.iv  = cause_q[CA_IV];

  // Code for the winning exception.
  logic [4:0] code;
  always_comb begin
    unique case (win)
      P_IBND:  code = EC_IBND;
      P_IADR:  code = EC_ADEL;
      P_IWCH:  code = EC_WATCH;
      P_IBUS:  code = EC_IBE;
      P_GRP9:  code = grp9_code;
      P_DBND:  code = EC_DBND;
      P_DADR:  code = data_is_store ? EC_ADES : EC_ADEL;
      P_DWCH:  code = EC_WATCH;
      P_DBUS:  code = EC_DBE;
      P_INTR:  code = EC_INT;
      default: code = EC_INT;
    endcase
  end

  // ------------------------------------------------------------------
  // Next state of the architectural registers.
  // ------------------------------------------------------------------
  wire [31:0] status_sw = wr_status ? reg_wdata : status_q;
  wire [31:0] cause_sw  = wr_cause ?
                          ((cause_q & ~CAUSE_WR_MASK) |
                           (reg_wdata & CAUSE_WR_MASK)) : cause_q;

  always_comb begin
    status_d = status_sw;
    cause_d  = cause_sw;
    epc_d    = wr_epc ? reg_wdata : epc_q;
    eepc_d   = wr_eepc ? reg_wdata : eepc_q;
    watch_d  = wr_watch ? reg_wdata[2:0] : watch_q;
    if (taken && win == P_COLD) begin
      status_d[ST_SR]    = 1'b0;
      status_d[ST_BIT21] = 1'b0;
      status_d[ST_ERL]   = 1'b1;
      status_d[ST_BEV]   = 1'b1;
      cause_d[CA_IV]     = 1'b0;
      watch_d[WA_IW]     = 1'b0;
      watch_d[WA_DWR]    = 1'b0;
      watch_d[WA_DWW]    = 1'b0;
      eepc_d             = pipe_pc;
    end else if (taken && is_rst_kind) begin
      // Warm reset and NMI share one register effect.
      eepc_d             = pipe_pc;
      status_d[ST_SR]    = 1'b1;
      status_d[ST_BIT21] = 1'b0;
      status_d[ST_ERL]   = 1'b1;
      status_d[ST_BEV]   = 1'b1;
    end else if (taken && is_cerr) begin
      eepc_d           = pipe_pc;
      status_d[ST_ERL] = 1'b1;
    end else if (is_gen) begin
      cause_d = {exc_bd, 1'b0, exc_ce, 12'h000,
                 cause_q[15:8], 1'b0, code, 2'b00};
      if (!status_q[ST_EXL]) begin
        epc_d = pipe_pc;
      end
      status_d[ST_EXL] = 1'b1;
    end
  end

  // An event in the cycle of the take still leaves the NMI pending.
  assign nmi_pend_d = nmi_fall | wr_nmi |
                      (nmi_pend_q & ~(taken && win == P_NMI));

  // ------------------------------------------------------------------
  // State registers.
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      status_q   <= STATUS_RST;
      cause_q    <= 32'h0000_0000;
      epc_q      <= 32'h0000_0000;
      eepc_q     <= 32'h0000_0000;
      watch_q    <= 3'h0;
      nmi_pend_q <= 1'b0;
    end else begin
      status_q   <= status_d;
      cause_q    <= cause_d;
      epc_q      <= epc_d;
      eepc_q     <= eepc_d;
      watch_q    <= watch_d;
      nmi_pend_q <= nmi_pend_d;
    end
  end

  // ------------------------------------------------------------------
  // Fetch redirection and port outputs.
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      redirect_valid  <= 1'b0;
      redirect_pc     <= VEC_RESET;
      flush_younger   <= 1'b0;
      reported_code   <= 5'h00;
      reported_prio   <= 4'h0;
      fetch_hold      <= 1'b0;
      cache_bus_reset <= 1'b0;
      reg_rdata       <= 32'h0000_0000;
      status_out      <= STATUS_RST;
    end else begin
      redirect_valid  <= taken;
      redirect_pc     <= taken ? sel.vector : redirect_pc;
      flush_younger   <= taken;
      reported_code   <= (taken && is_gen) ? code : reported_code;
      reported_prio   <= taken ? win : reported_prio;
      fetch_hold      <= rst_held;
      cache_bus_reset <= ~pin_s2_q[1] | warm_rise;
      reg_rdata       <= reg_rd ? rd_mux : 32'h0000_0000;
      status_out      <= status_d;
    end
  end

endmodule // exception_vector_priority_unit
`default_nettype wire

/* File: testbench/exc_unit_props.sv */
`timescale 1ns/1ps
`default_nettype none
module exc_unit_props
  import exc_pkg::*;
(
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Pipeline side.
  input wire logic [15:4] exc_raise,
  input wire logic [4:0]  grp9_code,
  input wire logic        instr_boundary,
  // Fetch side.
  input wire logic        redirect_valid,
  input wire logic [31:0] redirect_pc,
  input wire logic        flush_younger,
  input wire logic [4:0]  reported_code,
  input wire logic [3:0]  reported_prio,
  input wire logic        fetch_hold,
  input wire logic [31:0] status_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // --------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------
  logic gen_ok;
  logic is_cerr;
  assign gen_ok  = (|exc_raise) && !instr_boundary && !fetch_hold;
  assign is_cerr = reported_prio == P_ICER || reported_prio == P_DCER;

  a_flush_pair: assert property (redirect_valid == flush_younger)
    else $error("flush and redirect differ");
  a_exc_taken: assert property (gen_ok |=> redirect_valid)
    else $error("pipeline exception not taken");
  a_top_prio: assert property (gen_ok && exc_raise[4] |=> reported_prio == P_IBND)
    else $error("highest priority not reported");
  a_grp9_code: assert property (gen_ok && exc_raise[9:4] == 6'h20
    |=> reported_prio == P_GRP9 && reported_code == $past(grp9_code))
    else $error("group nine code wrong");
  a_intr_lowest: assert property (gen_ok && exc_raise == 12'h800
    |=> reported_prio == P_INTR && reported_code == EC_INT)
    else $error("interrupt report wrong");
  a_exl_set: assert property (redirect_valid && reported_prio >= P_IBND
    && !is_cerr |-> status_out[ST_EXL])
    else $error("exception level not set");
  a_reset_vec: assert property (redirect_valid && reported_prio <= P_NMI
    |-> redirect_pc == VEC_RESET && status_out[ST_ERL] && status_out[ST_BEV])
    else $error("reset vector wrong");
  a_soft_flag: assert property (redirect_valid && reported_prio <= P_NMI
    |-> status_out[ST_SR] == (reported_prio != P_COLD))
    else $error("soft reset flag wrong");
  a_cache_vec: assert property (redirect_valid && is_cerr |-> status_out[ST_ERL]
    && redirect_pc == (status_out[ST_BEV] ? 32'hBFC0_0300 : 32'hA000_0100))
    else $error("cache error vector wrong");
  a_gen_vec: assert property (redirect_valid && reported_prio >= P_IBND
    && reported_prio <= P_DBUS && !is_cerr |-> redirect_pc ==
    (status_out[ST_BEV] ? BASE_BEV1 : BASE_BEV0) + OFF_VGEN)
    else $error("general vector wrong");
endmodule // exc_unit_props

bind exception_vector_priority_unit exc_unit_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .exc_raise(exc_raise),
  .grp9_code(grp9_code), .instr_boundary(instr_boundary),
  .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
  .flush_younger(flush_younger), .reported_code(reported_code),
  .reported_prio(reported_prio), .fetch_hold(fetch_hold),
  .status_out(status_out)
);
`default_nettype wire

/* File: testbench/sys_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sys_pin_model (
  // Clock and requests.
  input  wire logic ref_clk,
  input  wire logic cold_req,
  input  wire logic hung_read,
  input  wire logic nmi_req,
  // Pins to the unit.
  output logic      cold_reset_n,
  output logic      warm_reset_n,
  output logic      nmi_n
);
  initial begin
    cold_reset_n = 1'b1;
    warm_reset_n = 1'b1;
    nmi_n        = 1'b1;
  end

  // A hung read is ended through the warm pin, never through NMI.
  always @(posedge ref_clk) begin
    cold_reset_n <= !cold_req;
    warm_reset_n <= !hung_read;
    nmi_n        <= !nmi_req;
  end
endmodule // sys_pin_model
`default_nettype wire

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import exc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n, cold_reset_n, warm_reset_n, nmi_n;
  logic cold_req, hung_read, nmi_req;
  logic [15:4] exc_raise;
  logic [4:0] grp9_code, reported_code;
  logic data_is_store, exc_bd, instr_boundary, reg_wr, reg_rd;
  logic [1:0] exc_ce;
  logic [31:0] pipe_pc, reg_wdata, reg_rdata, redirect_pc, status_out;
  logic [7:0] reg_addr;
  logic redirect_valid, flush_younger, fetch_hold, cache_bus_reset;
  logic [3:0] reported_prio;
  int errors = 0;
  int tests_run = 0;
  logic [4:0] code_tab [4:15] = '{5'h02, 5'h04, 5'h17, 5'h00, 5'h06,
    5'h0C, 5'h03, 5'h05, 5'h00, 5'h17, 5'h07, 5'h00};

  always #25 ref_clk = ~ref_clk;

  exception_vector_priority_unit dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .cold_reset_n(cold_reset_n), .warm_reset_n(warm_reset_n),
    .nmi_n(nmi_n), .exc_raise(exc_raise), .grp9_code(grp9_code),
    .data_is_store(data_is_store), .exc_bd(exc_bd), .exc_ce(exc_ce),
    .pipe_pc(pipe_pc), .instr_boundary(instr_boundary),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
    .flush_younger(flush_younger), .reported_code(reported_code),
    .reported_prio(reported_prio), .fetch_hold(fetch_hold),
    .cache_bus_reset(cache_bus_reset), .status_out(status_out));

  sys_pin_model partner (.ref_clk(ref_clk), .cold_req(cold_req),
    .hung_read(hung_read), .nmi_req(nmi_req),
    .cold_reset_n(cold_reset_n), .warm_reset_n(warm_reset_n),
    .nmi_n(nmi_n));

  // --------------------------------------------------------------
  // Access tasks.
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input string nm);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(nm, e, reg_rdata & m);
  endtask

  task automatic raise(input logic [15:4] r, input logic [31:0] pc);
    @(posedge ref_clk);
    exc_raise <= r;
    pipe_pc   <= pc;
    @(posedge ref_clk);
    exc_raise <= '0;
    #1;
  endtask

  task automatic wait_redir(input logic [3:0] p, input logic [31:0] pc);
    int n;
    n = 0;
    while (redirect_valid !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 40) begin
      errors++;
      $display("Error redirect_valid expected 1 seen 0");
      finish_test();
    end
    chk("reported_prio", {28'h0, p}, {28'h0, reported_prio});
    chk("redirect_pc", pc, redirect_pc);
  endtask

  // --------------------------------------------------------------
  // Main sequence.
  // --------------------------------------------------------------
  initial begin
    rst_n = 1'b0; exc_raise = '0; grp9_code = 5'h0C; data_is_store = 1'b1;
    exc_bd = 1'b1; exc_ce = 2'b01; pipe_pc = 32'h0; instr_boundary = 1'b0;
    reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    cold_req = 1'b0; hung_read = 1'b0; nmi_req = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(OFF_STATUS, STATUS_RST, '1, "status");
    rd(8'h20, 32'h0, '1, "unmapped");
    wr(OFF_CAUSE, 32'hFFFF_FFFF);
    rd(OFF_CAUSE, CAUSE_WR_MASK, '1, "cause_wr");
    wr(OFF_STATUS, 32'h0);
    raise(12'h800, 32'h1000);
    wait_redir(P_INTR, BASE_BEV0 + OFF_VINT);
    rd(OFF_EPC, 32'h1000, '1, "epc");
    rd(OFF_CAUSE, 32'h9000_0300, '1, "cause");
    for (int p = 4; p <= 15; p++) begin
      raise(12'h1 << (p - 4), 32'h2000);
      wait_redir(p[3:0], (p == 7 || p == 12) ? 32'hA000_0100 :
                 BASE_BEV0 + OFF_VGEN);
      if (p != 7 && p != 12) chk("code", code_tab[p], reported_code);
    end
    @(posedge ref_clk);
    data_is_store <= 1'b0;
    raise(12'h080, 32'h2000);
    wait_redir(P_DADR, BASE_BEV0 + OFF_VGEN);
    chk("load_code", {27'h0, EC_ADEL}, {27'h0, reported_code});
    rd(OFF_EPC, 32'h1000, '1, "epc_kept");
    raise(12'hFFF, 32'h2000);
    wait_redir(P_IBND, BASE_BEV0 + OFF_VGEN);
    raise(12'hFF8, 32'h2000);
    wait_redir(P_ICER, 32'hA000_0100);
    wr(OFF_STATUS, 32'h0040_0000);
    raise(12'h008, 32'h2000);
    wait_redir(P_ICER, 32'hBFC0_0300);
    raise(12'h020, 32'h2000);
    wait_redir(P_GRP9, BASE_BEV1 + OFF_VGEN);
    wr(OFF_INTREG, 32'h0000_0040);
    repeat (5) begin
      @(posedge ref_clk);
      #1;
      chk("no_nmi", 32'h0, {31'h0, redirect_valid});
    end
    @(posedge ref_clk);
    instr_boundary <= 1'b1;
    pipe_pc <= 32'h3000;
    wait_redir(P_NMI, VEC_RESET);
    rd(OFF_ERROR_EPC, 32'h3000, '1, "error_epc");
    rd(OFF_STATUS, 32'h0050_0006, '1, "nmi_status");
    @(posedge ref_clk);
    nmi_req <= 1'b1;
    wait_redir(P_NMI, VEC_RESET);
    @(posedge ref_clk);
    nmi_req <= 1'b0;
    instr_boundary <= 1'b0;
    wr(OFF_WATCH, 32'h7);
    @(posedge ref_clk);
    hung_read <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
    chk("cache_bus_reset", 32'h1, {31'h0, cache_bus_reset});
    chk("fetch_hold", 32'h1, {31'h0, fetch_hold});
    @(posedge ref_clk);
    hung_read <= 1'b0;
    pipe_pc <= 32'h4000;
    wait_redir(P_WARM, VEC_RESET);
    rd(OFF_ERROR_EPC, 32'h4000, '1, "warm_epc");
    rd(OFF_STATUS, 32'h0050_0004, 32'h0070_0004, "warm_st");
    rd(OFF_WATCH, 32'h7, 32'h7, "watch_kept");
    wr(OFF_CAUSE, 32'h0080_0000);
    @(posedge ref_clk);
    cold_req <= 1'b1;
    repeat (5) @(posedge ref_clk);
    cold_req <= 1'b0;
    wait_redir(P_COLD, VEC_RESET);
    rd(OFF_STATUS, 32'h0040_0004, 32'h0070_0004, "cold_st");
    rd(OFF_WATCH, 32'h0, 32'h7, "watch_clr");
    rd(OFF_CAUSE, 32'h0, 32'h0080_0000, "iv_clr");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
